// ---- core/ldc_core.sv ----
/*
  Control core of a 16-channel LED sink driver: serial input and status
  shift register, grayscale counter, staggered channel switching, blanking,
  open-LED and thermal error reporting, mode select and an APB control port.
  Assumes all pin inputs are asynchronous to pclk and slow against 40 MHz.
*/
// Behaviour
// - Error pin pulls low when thermal flag or any open-LED flag is set.
// - While blanked, open-LED flags do not reach the error pin.
// - Thermal flag follows the over-temperature sense; error pin follows.
// - Thermal flag is readable in the status word.
// - Open-LED flag needs channel on, detect delay elapsed, output voltage low.
// - Open-LED status is shifted out on serial data out.
// - Status word captures flags at latch strobe falling edge.
// - Channel n switches n fixed steps after channel 0.
// - The stagger applies to both turn-on and turn-off.
// - Blank forces all sixteen channels off, except during the tail after a short blank-low pulse.
// - Blank clears the grayscale counter.
// - Without blank, channels follow grayscale and dot correction.
// - Short blank-low pulse still gives each channel min(grayscale, low time).
// - Two select inputs choose shift length and correction source.
// - Programming level plus source select writes correction into EEPROM.
// - Data shifts in MSB first on shift clock rise; latch strobe transfers it.
// - Status bits 0-15 hold open-LED flags, bit 16 the thermal flag.
module ldc_core (
  // APB
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [7:0]              paddr,
  input  wire logic [31:0]             pwdata,
  output logic      [31:0]             prdata,
  output logic                         pready,
  output logic                         pslverr,
  // Host pins
  input  wire logic                    shift_clk,
  input  wire logic                    serial_data_in,
  input  wire logic                    latch_strobe,
  input  wire logic                    output_blank,
  input  wire logic [1:0]              program_voltage_select,
  input  wire logic                    dc_source_select,
  input  wire logic                    gs_clk,
  output logic                         serial_data_out,
  // Analog sense
  input  wire logic                    over_temp,
  input  wire logic [ldc_pkg::NCH-1:0] chan_low_volt,
  // Driver outputs
  output logic      [ldc_pkg::NCH-1:0]   channel_output,
  output logic      [ldc_pkg::SR_DC-1:0] channel_dc,
  output logic                           error_out_o,
  output logic                           error_out_oe_n
);
  import ldc_pkg::*;

  localparam int SW = NCH + 9;

  logic [SW-1:0]     raw_w;
  logic [SW-1:0]     syn_w;
  logic              sclk_s;
  logic              sin_s;
  logic              lat_s;
  logic              blank_pin_s;
  ldc_program_voltage_select_t         program_voltage_select_s;
  logic              dc_source_select_s;
  logic              gsclk_s;
  logic              otemp_s;
  logic [NCH-1:0]    lowv_s;

  logic              sclk_d_r;
  logic              lat_d_r;
  logic              gsclk_d_r;
  logic              dc_source_select_d_r;
  logic              blank_d_r;
  logic              sclk_rise;
  logic              lat_rise;
  logic              lat_fall;
  logic              gsclk_rise;
  logic              dc_source_select_rise;
  logic              blank_rise;

  logic [1:0]        ctrl_r;
  logic              blank;
  logic              gs_mode;
  logic              dc_mode;
  logic              prog_mode;

  logic [SR_GS-1:0]  sr_r;
  logic [SR_GS-1:0]  sid_w;
  logic [SR_GS-1:0]  gs_r;
  logic [SR_DC-1:0]  dc_r;
  logic [SR_DC-1:0]  ee_r;
  logic [SR_DC-1:0]  dc_act;

  logic [GSW-1:0]    gs_cnt_r;
  logic [NCH-1:0]    on_req;
  logic [NCH-1:0]    dly_r [DLY_DEPTH];
  logic [NCH-1:0]    chan_dly;
  logic [BLW-1:0]    blank_low_r;
  logic [TLW-1:0]    tail_r;
  logic              tail_act;
  logic              short_end;
  logic              force_off;

  logic [ODW-1:0]    on_cnt_r [NCH];
  logic [NCH-1:0]    lod_r;
  logic              tef_r;
  logic              lod_unmasked;

  logic              apb_acc;
  logic              apb_fire;
  logic              addr_ok;
  logic [31:0]       rd_mux;

  // Every pin crosses into pclk before use; shift_clk and gs_clk are sampled
  assign raw_w = {chan_low_volt, over_temp, gs_clk, dc_source_select,
                  program_voltage_select, output_blank, latch_strobe,
                  serial_data_in, shift_clk};

  ldc_sync #(.W(SW)) u_sync (
    .clk   (pclk),
    .rst_n (presetn),
    .d     (raw_w),
    .q     (syn_w)
  );

  assign sclk_s      = syn_w[0];
  assign sin_s       = syn_w[1];
  assign lat_s       = syn_w[2];
  assign blank_pin_s = syn_w[3];
  assign program_voltage_select_s      = ldc_program_voltage_select_t'(syn_w[5:4]);
  assign dc_source_select_s     = syn_w[6];
  assign gsclk_s     = syn_w[7];
  assign otemp_s     = syn_w[8];
  assign lowv_s      = syn_w[SW-1:9];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sclk_d_r  <= 1'b0;
      lat_d_r   <= 1'b0;
      gsclk_d_r <= 1'b0;
      dc_source_select_d_r <= 1'b0;
      blank_d_r <= 1'b1;
    end else begin
      sclk_d_r  <= sclk_s;
      lat_d_r   <= lat_s;
      gsclk_d_r <= gsclk_s;
      dc_source_select_d_r <= dc_source_select_s;
      blank_d_r <= blank;
    end
  end

  assign sclk_rise  = sclk_s & ~sclk_d_r;
  assign lat_rise   = lat_s & ~lat_d_r;
  assign lat_fall   = ~lat_s & lat_d_r;
  assign gsclk_rise = gsclk_s & ~gsclk_d_r;
  assign dc_source_select_rise = dc_source_select_s & ~dc_source_select_d_r;
  assign blank_rise = blank & ~blank_d_r;

  // Illegal select code is treated as grayscale mode
  assign dc_mode   = (program_voltage_select_s == LDC_PROGRAM_VOLTAGE_SELECT_VCC);
  assign prog_mode = (program_voltage_select_s == LDC_PROGRAM_VOLTAGE_SELECT_PROG);
  assign gs_mode   = ~dc_mode & ~prog_mode;
  assign blank     = blank_pin_s | ctrl_r[CTRL_BLANK_BIT];

  // Status word image
  always_comb begin
    sid_w = '0;
    sid_w[NCH-1:0] = lod_r;
    sid_w[SID_TEF_BIT] = tef_r;
    sid_w[SID_DC_LSB +: SR_DC] = dc_act;
  end

  // Shifting is held off while the strobe is high, since the correction latch dc_r is transparent then
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sr_r <= '0;
    end else if (lat_fall && gs_mode) begin
      sr_r <= sid_w;
    end else if (sclk_rise && !lat_s) begin
      sr_r <= {sr_r[SR_GS-2:0], sin_s};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      serial_data_out <= 1'b0;
    end else begin
      serial_data_out <= dc_mode ? sr_r[SR_DC-1] : sr_r[SR_GS-1];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gs_r <= '0;
    end else if (gs_mode && lat_rise) begin
      gs_r <= sr_r;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dc_r <= '0;
    end else if (dc_mode && lat_s) begin
      dc_r <= sr_r[SR_DC-1:0];
    end
  end

  // Non-volatile store starts from its erased default of all ones
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ee_r <= EE_RESET;
    end else if (prog_mode && dc_source_select_rise) begin
      ee_r <= dc_r;
    end
  end

  assign dc_act = dc_source_select_s ? dc_r : ee_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      channel_dc <= '0;
    end else begin
      channel_dc <= dc_act;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gs_cnt_r <= '0;
    end else if (blank) begin
      gs_cnt_r <= '0;
    end else if (gsclk_rise && gs_cnt_r != GS_MAX) begin
      gs_cnt_r <= gs_cnt_r + 12'h001;
    end
  end

  always_comb begin
    for (int n = 0; n < NCH; n++) begin
      on_req[n] = ~blank && gs_cnt_r != '0 && gs_cnt_r != GS_MAX &&
                  gs_cnt_r <= gs_field(gs_r, n);
    end
  end

  // One pipeline shared by all channels; each taps its own depth
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int k = 0; k < DLY_DEPTH; k++) begin
        dly_r[k] <= '0;
      end
    end else begin
      dly_r[0] <= on_req;
      for (int k = 1; k < DLY_DEPTH; k++) begin
        dly_r[k] <= dly_r[k-1];
      end
    end
  end

  always_comb begin
    for (int n = 0; n < NCH; n++) begin
      chan_dly[n] = dly_r[n*STEP_CYC][n];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      blank_low_r <= '0;
    end else if (blank) begin
      blank_low_r <= '0;
    end else if (blank_low_r != BLW'(SHORT_CYC)) begin
      blank_low_r <= blank_low_r + 1'b1;
    end
  end

  // After a short low pulse the late channels still play out their slice
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tail_r <= '0;
    end else if (short_end) begin
      tail_r <= TLW'(DLY_DEPTH);
    end else if (tail_r != '0) begin
      tail_r <= tail_r - 1'b1;
    end
  end

  // The rise that ends a short pulse must not cut the last slice of channel 0
  assign short_end = blank_rise && blank_low_r != '0 && blank_low_r < BLW'(SHORT_CYC);
  assign tail_act  = (tail_r != '0);
  assign force_off = blank & ~tail_act & ~short_end;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      channel_output <= '0;
    end else if (force_off) begin
      channel_output <= '0;
    end else begin
      channel_output <= chan_dly;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int n = 0; n < NCH; n++) begin
        on_cnt_r[n] <= '0;
      end
    end else begin
      for (int n = 0; n < NCH; n++) begin
        if (!channel_output[n]) begin
          on_cnt_r[n] <= '0;
        end else if (on_cnt_r[n] != ODW'(OPEN_DET_CYC)) begin
          on_cnt_r[n] <= on_cnt_r[n] + 1'b1;
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lod_r <= '0;
    end else begin
      for (int n = 0; n < NCH; n++) begin
        lod_r[n] <= channel_output[n] && lowv_s[n] &&
                    on_cnt_r[n] == ODW'(OPEN_DET_CYC);
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tef_r <= 1'b0;
    end else begin
      tef_r <= otemp_s;
    end
  end

  assign lod_unmasked = (|lod_r) & ~blank & ctrl_r[CTRL_LODEN_BIT];

  // Pin is only ever pulled low; the pull-up lives outside
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      error_out_o    <= 1'b0;
      error_out_oe_n <= 1'b1;
    end else begin
      error_out_o    <= 1'b0;
      error_out_oe_n <= ~(tef_r | lod_unmasked);
    end
  end

  // APB slave: one wait state, registered answer
  assign apb_acc  = psel & penable;
  assign apb_fire = apb_acc & pready;
  assign addr_ok  = (paddr == ADDR_CTRL) || (paddr == ADDR_STAT) ||
                    (paddr == ADDR_GSCNT);

  always_comb begin
    rd_mux = '0;
    unique case (paddr)
      ADDR_CTRL:  rd_mux[1:0] = ctrl_r;
      ADDR_STAT: begin
        rd_mux[NCH-1:0] = lod_r;
        rd_mux[STAT_TEF_BIT] = tef_r;
        rd_mux[STAT_BLANK_BIT] = blank;
        rd_mux[STAT_MODE_LSB +: 2] = program_voltage_select_s;
      end
      ADDR_GSCNT: rd_mux[GSW-1:0] = gs_cnt_r;
      default:    rd_mux = '0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end else if (apb_acc && !pready) begin
      pready  <= 1'b1;
      pslverr <= ~addr_ok;
      prdata  <= pwrite ? 32'h0000_0000 : rd_mux;
    end else begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= CTRL_RESET;
    end else if (apb_fire && pwrite && paddr == ADDR_CTRL) begin
      ctrl_r <= pwdata[1:0];
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_err_thermal_drive: assert property (tef_r |=> !error_out_oe_n)
    else $error("thermal flag did not pull error pin");
  chk_err_idle_release: assert property (!tef_r && lod_r == '0 |=> error_out_oe_n)
    else $error("error pin pulled without a flag");
  chk_err_blank_mask: assert property (blank && !tef_r |=> error_out_oe_n)
    else $error("open-LED flag reached error pin while blanked");
  chk_blank_forces_off: assert property (force_off |=> channel_output == '0)
    else $error("channel on while blanked");
  chk_blank_clears_cnt: assert property (blank |=> gs_cnt_r == '0)
    else $error("grayscale counter not cleared by blank");
  chk_lod_after_delay: assert property ($rose(lod_r[0]) |-> $past(on_cnt_r[0]) == ODW'(OPEN_DET_CYC))
    else $error("open-LED flag set before detect delay");
  chk_stagger_last_on: assert property (on_req[NCH-1] |-> ##16 chan_dly[NCH-1])
    else $error("last channel did not turn on at its stagger step");
  chk_stagger_last_off: assert property (!on_req[NCH-1] |-> ##16 !chan_dly[NCH-1])
    else $error("last channel did not turn off at its stagger step");
  chk_sid_capture: assert property (lat_fall && gs_mode |=> sr_r[SID_TEF_BIT:0] ==
      {$past(tef_r), $past(lod_r)})
    else $error("status word not captured at strobe fall");
  chk_ee_program: assert property (prog_mode && dc_source_select_rise |=> ee_r == $past(dc_r))
    else $error("EEPROM not written from correction register");
  chk_shift_msb_first: assert property (sclk_rise && !lat_s && !lat_fall |=>
      sr_r[0] == $past(sin_s) && sr_r[SR_GS-1:1] == $past(sr_r[SR_GS-2:0]))
    else $error("serial shift wrong");
  chk_short_tail: assert property (blank_rise && blank_low_r != '0 && blank_low_r < BLW'(SHORT_CYC)
      |=> tail_r == TLW'(DLY_DEPTH) ##1 !force_off)
    else $error("short blank pulse not played out");
  chk_dc_source: assert property (dc_source_select_s && $stable(dc_source_select_s) |=> channel_dc == $past(dc_r))
    else $error("correction source not the register");

  cov_lod_seen: cover property ($rose(lod_r[0]));
  cov_short_pulse: cover property (blank_rise && tail_r == '0 ##1 tail_act);
  cov_ee_write: cover property (prog_mode && dc_source_select_rise);
  cov_sid_read: cover property (lat_fall && gs_mode && !error_out_oe_n);

endmodule

// ---- shared/ldc_pkg.sv ----
/*
  Shared constants, types and helper functions for the LED driver
  control core: sizes, timing figures and the APB register map.
  Assumes a single 40 MHz system clock.
*/
package ldc_pkg;

  localparam int NCH   = 16;
  localparam int GSW   = 12;
  localparam int DCW   = 6;
  localparam int SR_GS = 192;
  localparam int SR_DC = 96;

  localparam int CLK_NS         = 25;
  localparam int OPEN_DET_NS    = 1000;
  localparam int STEP_NS        = 20;
  localparam int SHORT_BLANK_NS = 300;

  // Least times round up, longest times round down
  localparam int OPEN_DET_CYC = (OPEN_DET_NS + CLK_NS - 1) / CLK_NS;
  localparam int STEP_CYC     = (STEP_NS + CLK_NS - 1) / CLK_NS;
  localparam int SHORT_CYC    = SHORT_BLANK_NS / CLK_NS;
  localparam int DLY_DEPTH    = (NCH - 1) * STEP_CYC + 1;
  localparam int ODW          = $clog2(OPEN_DET_CYC + 1);
  localparam int TLW          = $clog2(DLY_DEPTH + 1);
  localparam int BLW          = $clog2(SHORT_CYC + 1);

  localparam int SID_TEF_BIT = 16;
  localparam int SID_DC_LSB  = 24;

  localparam logic [GSW-1:0]   GS_MAX   = 12'hFFF;
  localparam logic [SR_DC-1:0] EE_RESET = 96'hFFFF_FFFF_FFFF_FFFF_FFFF_FFFF;

  localparam logic [7:0] ADDR_CTRL  = 8'h00;
  localparam logic [7:0] ADDR_STAT  = 8'h04;
  localparam logic [7:0] ADDR_GSCNT = 8'h08;

  localparam int         CTRL_BLANK_BIT = 0;
  localparam int         CTRL_LODEN_BIT = 1;
  localparam logic [1:0] CTRL_RESET     = 2'h2;
  localparam int         STAT_TEF_BIT   = 16;
  localparam int         STAT_BLANK_BIT = 17;
  localparam int         STAT_MODE_LSB  = 18;

  typedef enum logic [1:0] {
    LDC_PROGRAM_VOLTAGE_SELECT_GND  = 2'b00,
    LDC_PROGRAM_VOLTAGE_SELECT_VCC  = 2'b01,
    LDC_PROGRAM_VOLTAGE_SELECT_PROG = 2'b10,
    LDC_PROGRAM_VOLTAGE_SELECT_BAD  = 2'b11
  } ldc_program_voltage_select_t;

  function automatic logic [GSW-1:0] gs_field(input logic [SR_GS-1:0] w, input int n);
    gs_field = w[n*GSW +: GSW];
  endfunction

endpackage

// ---- core/ldc_sync.sv ----
/*
  Two-flop synchroniser for a bundle of independent level inputs.
  Assumes each bit is a slow level or is oversampled by the caller.
*/
module ldc_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // Data
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= '0;
      q      <= '0;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end

endmodule

// ---- test/ldc_host_model.sv ----
/*
  Host controller model for the serial pins: shifts frames MSB first,
  pulses the latch strobe and collects the bits seen on the serial output.
  Assumes callers enter its tasks just after a rising pclk edge.
*/
module ldc_host_model (
  // Clock
  input  wire logic pclk,
  // Serial pins
  output logic      shift_clk,
  output logic      serial_data_in,
  output logic      latch_strobe,
  input  wire logic serial_data_out
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [191:0] got;

  initial begin
    shift_clk = 1'b0;
    serial_data_in = 1'b0;
    latch_strobe = 1'b0;
    got = '0;
  end

  // 200 ns shift period; shift clock stays low between frames
  task automatic frame(input logic [191:0] w, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      serial_data_in <= w[i];
      repeat (4) @(posedge pclk);
      got <= {got[190:0], serial_data_out};
      shift_clk <= 1'b1;
      repeat (4) @(posedge pclk);
      shift_clk <= 1'b0;
    end
    // Released data line must not look like a held bit
    serial_data_in <= ~w[0];
  endtask

  // Latch only after a whole frame; status is captured as it falls
  task automatic latch();
    latch_strobe <= 1'b1;
    repeat (4) @(posedge pclk);
    latch_strobe <= 1'b0;
    repeat (6) @(posedge pclk);
  endtask
endmodule

// ---- test/led_driver_error_blank_mode_ctrl_tb.sv ----
/*
  Self-checking bench for the LED driver control core: APB access, error
  pin, correction modes, grayscale stagger, blanking and status readout.
  Assumes the host model in ldc_host_model.sv and a pull-up on the error pin.
*/
module led_driver_error_blank_mode_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import ldc_pkg::*;

  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, slverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic output_blank, dc_source_select, gs_clk, over_temp, error_out_o, error_out_oe_n;
  logic [1:0] program_voltage_select;
  logic [NCH-1:0] chan_low_volt, channel_output, seen;
  logic [SR_DC-1:0] channel_dc, dcw;
  logic shift_clk, serial_data_in, latch_strobe, serial_data_out;
  logic [GSW-1:0] gsv [NCH];
  logic [SR_GS-1:0] gw;
  int seed, err_total, samples_checked, n;
  // Open-drain pin with external pull-up
  wire err_pin = error_out_oe_n ? 1'b1 : error_out_o;

  ldc_core dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .shift_clk(shift_clk), .serial_data_in(serial_data_in), .latch_strobe(latch_strobe),
    .output_blank(output_blank), .program_voltage_select(program_voltage_select),
    .dc_source_select(dc_source_select), .gs_clk(gs_clk), .serial_data_out(serial_data_out),
    .over_temp(over_temp), .chan_low_volt(chan_low_volt), .channel_output(channel_output),
    .channel_dc(channel_dc), .error_out_o(error_out_o), .error_out_oe_n(error_out_oe_n));

  ldc_host_model host (.pclk(pclk), .shift_clk(shift_clk), .serial_data_in(serial_data_in),
    .latch_strobe(latch_strobe), .serial_data_out(serial_data_out));

  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  function automatic logic [NCH-1:0] on_mask(input int cnt);
    for (int i = 0; i < NCH; i++) on_mask[i] = (gsv[i] >= cnt);
  endfunction

  function automatic logic [SR_GS-1:0] pack_gs();
    for (int i = 0; i < NCH; i++) pack_gs[i*GSW +: GSW] = gsv[i];
  endfunction

  function automatic logic [SR_GS-1:0] exp_sid(input logic [NCH-1:0] led_open_flag, input logic [SR_DC-1:0] dc);
    exp_sid = {72'h0, dc, 7'h0, 1'b0, led_open_flag};
  endfunction

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [191:0] seen_v, input logic [191:0] exp_v);
    samples_checked++;
    if (seen_v !== exp_v) begin
      err_total++;
      $display("BAD %s expected %0h seen %0h", what, exp_v, seen_v);
    end
  endtask

  task automatic give_up();
    err_total++;
    tally_and_finish();
  endtask

  // One APB transfer; waits for pready, then lets an edge pass idle
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      k++;
      if (k > 20) give_up();
      @(posedge pclk);
    end
    q = prdata;
    slverr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wait_pin(input logic v, input int lim, input string what);
    int k;
    k = 0;
    while (err_pin !== v) begin
      k++;
      if (k > lim) give_up();
      @(posedge pclk);
    end
    check(what, err_pin, v);
  endtask

  initial begin
    seed = 95952;
    err_total = 0;
    samples_checked = 0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {output_blank, dc_source_select, gs_clk, over_temp} = 4'h0;
    program_voltage_select = LDC_PROGRAM_VOLTAGE_SELECT_GND;
    chan_low_volt = 16'h0000;
    presetn = 1'b0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    check("err_pin reset", err_pin, 1'b1);
    check("channels reset", channel_output, 16'h0000);
    apb(1'b0, ADDR_CTRL, 32'h0);
    check("ctrl reset", q, 32'(CTRL_RESET));
    apb(1'b1, ADDR_CTRL, 32'h3);
    apb(1'b0, ADDR_STAT, 32'h0);
    check("stat blank", q[STAT_BLANK_BIT], 1'b1);
    apb(1'b1, ADDR_CTRL, 32'h2);
    apb(1'b0, 8'h0C, 32'h0);
    check("unmapped err", {slverr, q}, 33'h1_0000_0000);
    $display("test apb done");

    over_temp <= 1'b1;
    wait_pin(1'b0, 8, "err_pin hot");
    apb(1'b0, ADDR_STAT, 32'h0);
    check("stat thermal", q[STAT_TEF_BIT], 1'b1);
    output_blank <= 1'b1;
    over_temp <= 1'b0;
    wait_pin(1'b1, 8, "err_pin cool");
    $display("test thermal done");

    dcw = {$random(seed), $random(seed), $random(seed)};
    program_voltage_select <= LDC_PROGRAM_VOLTAGE_SELECT_VCC;
    host.frame(192'(dcw), SR_DC);
    host.latch();
    dc_source_select <= 1'b1;
    repeat (6) @(posedge pclk);
    check("dc register", channel_dc, dcw);
    dc_source_select <= 1'b0;
    repeat (6) @(posedge pclk);
    check("dc eeprom default", channel_dc, EE_RESET);
    program_voltage_select <= LDC_PROGRAM_VOLTAGE_SELECT_PROG;
    repeat (4) @(posedge pclk);
    dc_source_select <= 1'b1;
    repeat (6) @(posedge pclk);
    dc_source_select <= 1'b0;
    repeat (6) @(posedge pclk);
    check("dc eeprom written", channel_dc, dcw);
    $display("test modes done");

    for (int i = 0; i < NCH; i++) gsv[i] = GSW'($random(seed) & 3);
    gsv[0] = 12'h002;
    gsv[1] = 12'h000;
    gsv[2] = 12'h001;
    gsv[15] = 12'h001;
    gw = pack_gs();
    chan_low_volt <= 16'($random(seed)) | 16'h0001;
    program_voltage_select <= LDC_PROGRAM_VOLTAGE_SELECT_GND;
    host.frame(gw, SR_GS);
    host.latch();
    check("blanked channels", channel_output, 16'h0000);
    output_blank <= 1'b0;
    repeat (4) @(posedge pclk);
    gs_clk <= 1'b1;
    n = 0;
    while (channel_output === 16'h0000) begin
      n++;
      if (n > 20) give_up();
      @(posedge pclk);
    end
    check("first channel alone", channel_output, 16'h0001);
    repeat (20) @(posedge pclk);
    check("channels on", channel_output, on_mask(1));
    check("err_pin before delay", err_pin, 1'b1);
    gs_clk <= 1'b0;
    repeat (4) @(posedge pclk);
    gs_clk <= 1'b1;
    n = 0;
    while (channel_output === on_mask(1)) begin
      n++;
      if (n > 20) give_up();
      @(posedge pclk);
    end
    check("last still on", channel_output[15], 1'b1);
    gs_clk <= 1'b0;
    wait_pin(1'b0, 80, "err_pin open");
    // Late channels with count 1 are still inside their turn-off stagger
    repeat (NCH) @(posedge pclk);
    check("channels count 2", channel_output, on_mask(2));
    host.frame(gw, SR_GS);
    host.latch();
    host.frame(gw, SR_GS);
    check("status word", host.got, exp_sid(on_mask(2) & chan_low_volt, dcw));
    apb(1'b0, ADDR_GSCNT, 32'h0);
    check("count", q, 32'h2);
    output_blank <= 1'b1;
    wait_pin(1'b1, 8, "err_pin blanked");
    check("blank off", channel_output, 16'h0000);
    apb(1'b0, ADDR_GSCNT, 32'h0);
    check("count cleared", q, 32'h0);
    $display("test grayscale done");

    output_blank <= 1'b0;
    repeat (3) @(posedge pclk);
    gs_clk <= 1'b1;
    repeat (5) @(posedge pclk);
    output_blank <= 1'b1;
    seen = '0;
    repeat (30) begin
      @(posedge pclk);
      seen = seen | channel_output;
    end
    gs_clk <= 1'b0;
    check("short blank", seen, on_mask(1));
    check("off after short", channel_output, 16'h0000);
    $display("test short blank done");
    tally_and_finish();
  end
endmodule
